// ### wgc_pkg.sv
// Constants, types and register map of the write guard error checker
// =====================================================================
// Overview of operation
// R1: Unlock command acknowledged, arms write latch
// R2: Successful protected command clears the latch
// R3: Non-protect errors leave an armed latch armed
// R4: Persistent rate writes working and stored copy
// R5: Any error aborts command without side effects
// R6: Error reply: question mark, address, space, text
// R7: Nine errors, each with distinct first character
// R8: Address 00,0D,24,23 or above 7F rejected
// R9: Appended two hex characters checked as checksum
// R10: Unknown or lower-case mnemonic is command error
// R11: Span, clamp or limit switch gives limit error
// R12: Manual mode blocks analog and raw output
// R13: Parity error only when parity checking enabled
// R14: Wrong structure gives the syntax error
// R15: Non-digit or non-hex operand gives value error
// R16: Trim commands refused while output is slewing
// R17: Output trim beyond range gives value error
// R18: Unarmed nonvolatile writes get write-protect error
// R19: Config store keeps word, config read returns it; the config read reply here carries no word, only REG_CONFIG returns it
// R20: Config operand exactly eight hex characters
// R21: First hex character carries byte bits 7..4
// R22: Non-hex character cancels store with syntax error
// R23: New baud code waits for a module restart
// R24: New parity applies after the store reply
// R25: Latch cleared at power-up and remote restart
// R26: One error reported, structure before semantics
package wgc_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_FLAGS = 8'h04;
   localparam logic [7:0] REG_OPND_HI = 8'h08;
   localparam logic [7:0] REG_OPND_LO = 8'h0c;
   localparam logic [7:0] REG_VALUE = 8'h10;
   localparam logic [7:0] REG_SUM = 8'h14;
   localparam logic [7:0] REG_CTRL = 8'h18;
   localparam logic [7:0] REG_STATUS = 8'h1c;
   localparam logic [7:0] REG_CONFIG = 8'h20;
   localparam logic [7:0] REG_ACTIVE = 8'h24;
   localparam logic [7:0] REG_RATE = 8'h28;
   localparam logic [7:0] REG_NV_RATE = 8'h2c;
   localparam logic [7:0] REG_REPLY = 8'h30;
   localparam int CMD_LOWER_BIT = 8;
   localparam int CTRL_GO_BIT = 0;
   localparam int CTRL_SENT_BIT = 1;
   localparam int SUM_PRESENT_BIT = 24;
   localparam int CFG_LF_BIT = 23;
   localparam int CFG_PODD_BIT = 22;
   localparam int CFG_PEN_BIT = 21;
   localparam int CFG_BAUD_LSB = 16;
   localparam int OPND_CHARS = 8;
   localparam logic [3:0] OPND_LEN_CFG = 4'h8;
   localparam logic [31:0] CFG_RESET = 32'h31070180;
   localparam logic [31:0] RATE_RESET = 32'h00000000;
   localparam logic [7:0] ADDR_NUL = 8'h00;
   localparam logic [7:0] ADDR_CR = 8'h0d;
   localparam logic [7:0] ADDR_DOLLAR = 8'h24;
   localparam logic [7:0] ADDR_HASH = 8'h23;
   localparam logic [7:0] ADDR_MAX = 8'h7f;
   localparam logic [7:0] CH_QUERY = 8'h3f;
   localparam logic [7:0] CH_ACK = 8'h2a;
   localparam logic [7:0] CH_SPACE = 8'h20;
   localparam logic [7:0] CH_ADDR = 8'h41;
   localparam logic [7:0] CH_SUM = 8'h42;
   localparam logic [7:0] CH_CMD = 8'h43;
   localparam logic [7:0] CH_LIM = 8'h4c;
   localparam logic [7:0] CH_MAN = 8'h4d;
   localparam logic [7:0] CH_PAR = 8'h50;
   localparam logic [7:0] CH_SYN = 8'h53;
   localparam logic [7:0] CH_VAL = 8'h56;
   localparam logic [7:0] CH_WP = 8'h57;
   typedef enum logic [4:0] {
      write_unlock_cmd, persist_rate_cmd, config_store_cmd, config_read_cmd,
      analog_set_cmd, raw_set_cmd, span_floor_cmd, span_ceiling_cmd,
      bottom_clamp_cmd, top_clamp_cmd, trim_low_cmd, trim_high_cmd,
      readback_trim_low_cmd, readback_trim_high_cmd, remote_restart_cmd,
      other_read_cmd, other_store_cmd
   } wgc_cmd_t;
   localparam logic [4:0] CMD_COUNT = 5'h11;
   typedef enum logic [3:0] {
      err_none, err_address, err_checksum, err_command, err_limit,
      err_manual, err_parity, err_syntax, err_value, err_protect
   } wgc_err_t;
   typedef struct packed {
      logic [3:0] opnd_len;
      logic trim_range;
      logic slewing;
      logic manual;
      logic limit_sw;
      logic clamp;
      logic span;
      logic digit_bad;
      logic struct_bad;
      logic parity_bad;
   } wgc_flags_t;
   typedef struct packed {
      logic linefeed;
      logic par_odd;
      logic par_en;
      logic [2:0] baud;
   } wgc_act_t;
endpackage

// ### wgc_checker.sv
// Command checker with write-enable latch and APB register access
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module wgc_checker import wgc_pkg::*; #(
   parameter logic [31:0] CFG_INIT = CFG_RESET
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic write_enable,
   output logic [31:0] config_word,
   output wgc_act_t link_cfg,
   output logic [31:0] slew_rate
);

   // ===================================================================
   // Helpers
   function automatic logic [4:0] hex_dec(input logic [7:0] c);
      logic [4:0] r;
      r = 5'h00;
      if (c >= 8'h30 && c <= 8'h39) begin
         r = {1'b1, c[3:0]};
      end else if (c >= 8'h41 && c <= 8'h46) begin
         r = {1'b1, c[3:0] + 4'h9};
      end
      return r;
   endfunction

   function automatic wgc_act_t act_of(input logic [31:0] w);
      wgc_act_t a;
      a.linefeed = w[CFG_LF_BIT];
      a.par_odd = w[CFG_PODD_BIT];
      a.par_en = w[CFG_PEN_BIT];
      a.baud = w[CFG_BAUD_LSB +: 3];
      return a;
   endfunction

   function automatic logic [7:0] err_char(input wgc_err_t e);
      logic [7:0] c;
      case (e)
         err_address: c = CH_ADDR;
         err_checksum: c = CH_SUM;
         err_command: c = CH_CMD;
         err_limit: c = CH_LIM;
         err_manual: c = CH_MAN;
         err_parity: c = CH_PAR;
         err_syntax: c = CH_SYN;
         err_value: c = CH_VAL;
         err_protect: c = CH_WP;
         default: c = 8'h00;
      endcase
      return c;
   endfunction

   // ===================================================================
   // State
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [4:0] code_q;
   logic lower_q;
   wgc_flags_t flags_q;
   logic [31:0] opnd_hi_q;
   logic [31:0] opnd_lo_q;
   logic [31:0] value_q;
   logic [24:0] sum_q;
   logic [31:0] cfg_q;
   wgc_act_t act_q;
   logic par_pend_q;
   logic [1:0] par_new_q;
   logic wr_en_q;
   logic wr_en_d;
   logic [31:0] rate_ram_q;
   logic [31:0] rate_nv_q;
   logic done_q;
   logic ok_q;
   wgc_err_t err_q;
   logic [31:0] reply_q;

   // ===================================================================
   // APB slave, one wait-free access phase
   logic setup;
   logic access;
   logic wr_acc;
   logic hit;
   logic [31:0] rd_data;
   logic [31:0] status;

   assign setup = psel & ~penable;
   assign access = psel & penable & pready_q;
   assign wr_acc = access & pwrite & ~pslverr_q;

   assign hit = (paddr == REG_CMD) | (paddr == REG_FLAGS) |
                (paddr == REG_OPND_HI) | (paddr == REG_OPND_LO) |
                (paddr == REG_VALUE) | (paddr == REG_SUM) |
                (paddr == REG_CTRL) | (paddr == REG_STATUS) |
                (paddr == REG_CONFIG) | (paddr == REG_ACTIVE) |
                (paddr == REG_RATE) | (paddr == REG_NV_RATE) |
                (paddr == REG_REPLY);

   assign status = {6'h00, par_pend_q, wr_en_q, cfg_q[31:24],
                    err_char(err_q), 2'b00, err_q, ok_q, done_q};

   assign rd_data =
      (paddr == REG_CMD) ? {23'h0, lower_q, 3'h0, code_q} :
      (paddr == REG_FLAGS) ? {19'h0, flags_q} :
      (paddr == REG_OPND_HI) ? opnd_hi_q :
      (paddr == REG_OPND_LO) ? opnd_lo_q :
      (paddr == REG_VALUE) ? value_q :
      (paddr == REG_SUM) ? {7'h0, sum_q} :
      (paddr == REG_STATUS) ? status :
      (paddr == REG_CONFIG) ? cfg_q :
      (paddr == REG_ACTIVE) ? {26'h0, act_q} :
      (paddr == REG_RATE) ? rate_ram_q :
      (paddr == REG_NV_RATE) ? rate_nv_q :
      (paddr == REG_REPLY) ? reply_q : 32'h0;

   // Answer prepared at setup, so access completes on its first edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup & ~hit;
         prdata_q <= (setup & ~pwrite & hit) ? rd_data : 32'h0;
      end
   end

   logic go;
   logic sent;
   assign go = wr_acc & (paddr == REG_CTRL) & pwdata[CTRL_GO_BIT];
   assign sent = wr_acc & (paddr == REG_CTRL) & pwdata[CTRL_SENT_BIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_q <= 5'h00;
         lower_q <= 1'b0;
         flags_q <= '0;
         opnd_hi_q <= 32'h0;
         opnd_lo_q <= 32'h0;
         value_q <= 32'h0;
         sum_q <= 25'h0;
      end else if (wr_acc) begin
         if (paddr == REG_CMD) begin
            code_q <= pwdata[4:0];
            lower_q <= pwdata[CMD_LOWER_BIT];
         end
         if (paddr == REG_FLAGS) flags_q <= pwdata[12:0];
         if (paddr == REG_OPND_HI) opnd_hi_q <= pwdata;
         if (paddr == REG_OPND_LO) opnd_lo_q <= pwdata;
         if (paddr == REG_VALUE) value_q <= pwdata;
         if (paddr == REG_SUM) sum_q <= pwdata[24:0];
      end
   end

   // ===================================================================
   // Operand decode, byte 1 first, high nibble first
   logic [63:0] opnd_all;
   logic [4:0] dec [OPND_CHARS];
   logic [OPND_CHARS-1:0] hv;
   logic [OPND_CHARS-1:0] used_ok;
   logic [31:0] word;
   assign opnd_all = {opnd_hi_q, opnd_lo_q};

   for (genvar gi = 0; gi < OPND_CHARS; gi++) begin : g_hex
      assign dec[gi] = hex_dec(opnd_all[63-8*gi -: 8]);
      assign hv[gi] = dec[gi][4];
      assign word[31-4*gi -: 4] = dec[gi][3:0]; // R21
      assign used_ok[gi] = hv[gi] | (4'(gi) >= flags_q.opnd_len);
   end

   // ===================================================================
   // Classification
   wgc_cmd_t cmd;
   logic known;
   logic is_cfg;
   logic is_ao;
   logic is_raw;
   logic is_trim;
   logic is_otrim;
   logic is_prot;
   assign cmd = wgc_cmd_t'(code_q);
   assign known = code_q < CMD_COUNT;
   assign is_cfg = cmd == config_store_cmd;
   assign is_ao = cmd == analog_set_cmd;
   assign is_raw = cmd == raw_set_cmd;
   assign is_otrim = (cmd == trim_low_cmd) | (cmd == trim_high_cmd);
   assign is_trim = is_otrim | (cmd == readback_trim_low_cmd) |
                    (cmd == readback_trim_high_cmd);
   assign is_prot = (cmd == persist_rate_cmd) | is_cfg |
                    (cmd == remote_restart_cmd) | (cmd == other_store_cmd);

   logic [4:0] sum_hi;
   logic [4:0] sum_lo;
   logic par_err;
   logic sum_err;
   logic cmd_err;
   logic syn_err;
   logic val_err;
   logic addr_err;
   logic man_err;
   logic lim_err;
   logic prot_err;
   wgc_err_t err_d;

   assign sum_hi = hex_dec(sum_q[15:8]);
   assign sum_lo = hex_dec(sum_q[23:16]);
   assign par_err = flags_q.parity_bad & act_q.par_en; // R13
   assign sum_err = sum_q[SUM_PRESENT_BIT] & // R9
                    (~sum_hi[4] | ~sum_lo[4] |
                     ({sum_hi[3:0], sum_lo[3:0]} != sum_q[7:0]));
   assign cmd_err = lower_q | ~known; // R10
   assign syn_err = flags_q.struct_bad | // R14
                    (is_cfg & ((flags_q.opnd_len != OPND_LEN_CFG) | ~&hv)); // R20 R22
   assign val_err = flags_q.digit_bad | (is_raw & ~&used_ok) | // R15
                    (is_trim & flags_q.slewing) | // R16
                    (is_otrim & flags_q.trim_range); // R17
   assign addr_err = is_cfg & ((word[31:24] == ADDR_NUL) | // R8
                    (word[31:24] == ADDR_CR) | (word[31:24] == ADDR_DOLLAR) |
                    (word[31:24] == ADDR_HASH) | (word[31:24] > ADDR_MAX));
   assign man_err = (is_ao | is_raw) & flags_q.manual; // R12
   assign lim_err = is_ao & (flags_q.span | flags_q.clamp | flags_q.limit_sw); // R11
   assign prot_err = is_prot & ~wr_en_q; // R18

   // Structure and characters first, protection last
   assign err_d = par_err ? err_parity : // R26
                  sum_err ? err_checksum :
                  cmd_err ? err_command :
                  syn_err ? err_syntax :
                  val_err ? err_value :
                  addr_err ? err_address :
                  man_err ? err_manual :
                  lim_err ? err_limit :
                  prot_err ? err_protect : err_none;

   logic ok_d;
   assign ok_d = err_d == err_none;

   // Unlock arms, any other success disarms, errors leave it alone
   assign wr_en_d = !go ? wr_en_q : // R3
                    !ok_d ? wr_en_q :
                    (cmd == write_unlock_cmd); // R1 R2 R25

   // ===================================================================
   // Outcome recorded on every go, side effects only on success
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_q <= 1'b0;
         ok_q <= 1'b0;
         err_q <= err_none;
         reply_q <= 32'h0;
         wr_en_q <= 1'b0; // R25
      end else begin
         wr_en_q <= wr_en_d;
         if (go) begin
            done_q <= 1'b1;
            ok_q <= ok_d;
            err_q <= err_d;
            reply_q <= ok_d ? {CH_ACK, cfg_q[31:24], 16'h0} : // R1
                       {CH_QUERY, cfg_q[31:24], CH_SPACE, err_char(err_d)}; // R6 R7
         end
      end
   end

   // Stored data only moves on a clean command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= CFG_INIT;
         rate_ram_q <= RATE_RESET;
         rate_nv_q <= RATE_RESET;
      end else if (go & ok_d) begin // R5
         if (is_cfg) cfg_q <= word; // R19
         if (cmd == persist_rate_cmd) begin
            rate_ram_q <= value_q; // R4
            rate_nv_q <= value_q;
         end
      end
   end

   // Baud waits for restart so the link is not lost mid-session
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_q <= act_of(CFG_INIT);
         par_pend_q <= 1'b0;
         par_new_q <= 2'b00;
      end else begin
         if (go & ok_d & is_cfg) begin
            act_q.linefeed <= word[CFG_LF_BIT];
            par_pend_q <= 1'b1; // R24
            par_new_q <= {word[CFG_PODD_BIT], word[CFG_PEN_BIT]};
         end else if (sent & par_pend_q) begin
            par_pend_q <= 1'b0; // R24
            act_q.par_odd <= par_new_q[1];
            act_q.par_en <= par_new_q[0];
         end
         if (go & ok_d & (cmd == remote_restart_cmd)) begin
            act_q <= act_of(cfg_q); // R23
            par_pend_q <= 1'b0;
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign write_enable = wr_en_q;
   assign config_word = cfg_q;
   assign link_cfg = act_q;
   assign slew_rate = rate_ram_q;

   // ===================================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_unlock_arms: assert property ( // R1
      go && ok_d && cmd == write_unlock_cmd |=> wr_en_q && reply_q[31:24] == CH_ACK)
      else $error("unlock did not arm latch");
   a_success_disarms: assert property ( // R2
      go && ok_d && is_prot |=> !wr_en_q ##1 !wr_en_q)
      else $error("latch still armed after protected write");
   a_error_keeps: assert property ( // R3
      go && wr_en_q && !ok_d |=> wr_en_q)
      else $error("error dropped armed latch");
   a_rate_store: assert property ( // R4
      go && ok_d && cmd == persist_rate_cmd |=>
      rate_ram_q == $past(value_q) && rate_nv_q == $past(value_q))
      else $error("rate not stored in both copies");
   a_abort_clean: assert property ( // R5
      go && !ok_d |=> $stable(cfg_q) && $stable(rate_nv_q) && !ok_q)
      else $error("aborted command changed state");
   a_reply_head: assert property ( // R6
      go && !ok_d |=> reply_q[31:24] == CH_QUERY && reply_q[15:8] == CH_SPACE
      && reply_q[23:16] == $past(cfg_q[31:24]))
      else $error("error reply header wrong");
   a_first_char: assert property ( // R7
      go && prot_err && !par_err && !sum_err && !cmd_err && !syn_err
      && !val_err && !addr_err && !man_err && !lim_err |=> reply_q[7:0] == CH_WP)
      else $error("protect error text wrong");
   a_addr_reject: assert property ( // R8
      go && is_cfg && &hv && word[31:24] == ADDR_DOLLAR |=> !ok_q && $stable(cfg_q))
      else $error("illegal address accepted");
   a_sum_reject: assert property ( // R9
      go && sum_err |=> !ok_q && $stable(cfg_q))
      else $error("bad checksum accepted");
   a_parity_off: assert property ( // R13
      go && !act_q.par_en |=> err_q != err_parity)
      else $error("parity flagged while disabled");
   a_protect_gate: assert property ( // R18
      go && is_prot && !wr_en_q |=> !ok_q && $stable(rate_nv_q))
      else $error("unarmed write succeeded");
   a_baud_defer: assert property ( // R23
      !(go && ok_d && cmd == remote_restart_cmd) |=> $stable(act_q.baud))
      else $error("baud changed without restart");
   a_apb_answer: assert property (
      setup |=> pready_q ##1 !pready_q)
      else $error("apb answer timing wrong");

   c_unlock_store: cover property (
      go && ok_d && cmd == write_unlock_cmd ##[1:40] go && ok_d && is_cfg);
   c_protect_err: cover property (go && err_d == err_protect);
   c_retry_armed: cover property (
      go && !ok_d && wr_en_q ##[1:40] go && ok_d && is_prot);
   c_parity_apply: cover property (par_pend_q ##1 !par_pend_q);

endmodule // wgc_checker

// ### wgc_host.sv
// Host model: APB master that stands in for the serial command source
`timescale 1ns/1ps
module wgc_host import wgc_pkg::*; (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [ADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // =====================================================================
   // One transfer: setup, then access until pready; never assumes a latency
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the bench watchdog ends a wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released address and data lines flip so a stale value cannot pass for a request
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule // wgc_host

// ### tb.sv
// Self-checking testbench for the write guard error checker
`timescale 1ns/1ps
module tb import wgc_pkg::*;;
   localparam logic [31:0] F_PAR = 32'h1, F_SYN = 32'h2, F_DIG = 32'h4, F_SPAN = 32'h8;
   localparam logic [31:0] F_CLMP = 32'h10, F_LSW = 32'h20, F_MAN = 32'h40, F_SLEW = 32'h80;
   localparam logic [31:0] F_TRIM = 32'h100, F_LEN8 = 32'h1000, F_LEN7 = 32'he00;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, write_enable;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, config_word, slew_rate, st, rp, rv;
   wgc_act_t link_cfg;
   logic [7:0] cur_addr;
   int n_mismatch, comparisons;

   wgc_checker i_wgc_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .write_enable(write_enable),
      .config_word(config_word), .link_cfg(link_cfg), .slew_rate(slew_rate));
   wgc_host i_wgc_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   always #2.5 pclk = ~pclk;

   // =====================================================================
   // Reporting and bus helpers
   task automatic stop_test();
      if (n_mismatch == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic fail(input string m);
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, m);
   endtask
   task automatic chk_word(input logic [31:0] g, input logic [31:0] x, input string m);
      comparisons++;
      if (g !== x) fail(m);
   endtask
   task automatic chk_bit(input logic g, input logic x, input string m);
      comparisons++;
      if (g !== x) fail(m);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      i_wgc_host.xfer(1'b1, a, d, r, e);
      if (e !== 1'b0) fail("write refused");
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic e;
      i_wgc_host.xfer(1'b0, a, 32'h0, d, e);
      if (e !== 1'b0) fail("read refused");
   endtask
   // Char 1 of the operand carries the top nibble
   function automatic logic [63:0] asc(input logic [31:0] v);
      for (int i = 0; i < 8; i++)
         asc[8*i +: 8] = (v[4*i +: 4] < 4'ha) ? {4'h3, v[4*i +: 4]} : 8'h37 + v[4*i +: 4];
   endfunction
   task automatic run(input logic [8:0] c, input logic [31:0] f, input logic [63:0] op,
         input logic [31:0] sm);
      wr(REG_CMD, {23'h0, c});
      wr(REG_FLAGS, f);
      wr(REG_OPND_HI, op[63:32]);
      wr(REG_OPND_LO, op[31:0]);
      wr(REG_SUM, sm);
      wr(REG_CTRL, 32'h1);
      rd(REG_STATUS, st);
      rd(REG_REPLY, rp);
   endtask
   task automatic res(input wgc_err_t e, input logic [7:0] ch);
      chk_word({26'h0, st[5:0]}, {26'h0, e, e == err_none, 1'b1}, "status");
      chk_word(rp, (e == err_none) ? {CH_ACK, cur_addr, 16'h0}
         : {CH_QUERY, cur_addr, CH_SPACE, ch}, "reply");
   endtask
   task automatic cmd(input wgc_cmd_t c, input logic [31:0] f, input logic [63:0] op,
         input logic [31:0] sm, input wgc_err_t e, input logic [7:0] ch);
      run({4'h0, c}, f, op, sm);
      res(e, ch);
   endtask
   task automatic cmd0(input wgc_cmd_t c, input logic [31:0] f, input wgc_err_t e,
         input logic [7:0] ch);
      cmd(c, f, 64'h0, 32'h0, e, ch);
   endtask
   task automatic unlock();
      cmd0(write_unlock_cmd, 32'h0, err_none, 8'h00);
      chk_bit(write_enable, 1'b1, "latch not armed");
   endtask

   // =====================================================================
   // Scenarios
   task automatic t_reset();
      logic e;
      chk_bit(write_enable, 1'b0, "latch after reset");
      chk_word(config_word, CFG_RESET, "setup after reset");
      chk_word({26'h0, link_cfg}, 32'h7, "link after reset");
      chk_word(slew_rate, RATE_RESET, "rate after reset");
      i_wgc_host.xfer(1'b1, 8'h40, 32'h0, rv, e);
      chk_bit(e, 1'b1, "unmapped write");
      i_wgc_host.xfer(1'b0, 8'h40, 32'h0, rv, e);
      chk_bit(e, 1'b1, "unmapped read");
      chk_word(rv, 32'h0, "unmapped data");
   endtask
   task automatic t_protect();
      wr(REG_VALUE, 32'h2710);
      cmd0(persist_rate_cmd, 32'h0, err_protect, CH_WP);
      cmd0(remote_restart_cmd, 32'h0, err_protect, CH_WP);
      cmd(config_store_cmd, F_LEN8, asc(32'h31220180), 32'h0, err_protect, CH_WP);
      chk_word(slew_rate, RATE_RESET, "rate while locked");
      chk_word(config_word, CFG_RESET, "setup while locked");
      unlock();
      cmd0(persist_rate_cmd, 32'h0, err_none, 8'h00);
      chk_word(slew_rate, 32'h2710, "working rate");
      rd(REG_NV_RATE, rv);
      chk_word(rv, 32'h2710, "stored rate");
      chk_bit(write_enable, 1'b0, "latch after write");
      cmd0(persist_rate_cmd, 32'h0, err_protect, CH_WP);
      cmd0(persist_rate_cmd, F_SYN, err_syntax, CH_SYN);
   endtask
   task automatic t_keep();
      unlock();
      cmd0(config_read_cmd, F_SYN, err_syntax, CH_SYN);
      chk_bit(write_enable, 1'b1, "latch lost");
      cmd0(analog_set_cmd, F_SPAN, err_limit, CH_LIM);
      chk_bit(write_enable, 1'b1, "latch lost");
      cmd0(config_read_cmd, 32'h0, err_none, 8'h00);
      chk_bit(write_enable, 1'b0, "latch kept");
   endtask
   task automatic t_errors();
      wgc_cmd_t tr[4];
      tr = '{trim_low_cmd, trim_high_cmd, readback_trim_low_cmd, readback_trim_high_cmd};
      run(9'h011, 32'h0, 64'h0, 32'h0);
      res(err_command, CH_CMD);
      run({4'h8, config_read_cmd}, 32'h0, 64'h0, 32'h0);
      res(err_command, CH_CMD);
      cmd0(analog_set_cmd, F_CLMP, err_limit, CH_LIM);
      cmd0(analog_set_cmd, F_LSW, err_limit, CH_LIM);
      cmd0(analog_set_cmd, F_MAN | F_SPAN, err_manual, CH_MAN);
      cmd0(analog_set_cmd, F_SYN | F_MAN, err_syntax, CH_SYN);
      cmd0(analog_set_cmd, F_DIG | F_SPAN, err_value, CH_VAL);
      cmd0(config_read_cmd, F_PAR, err_none, 8'h00);
      foreach (tr[i])
         cmd0(tr[i], F_SLEW, err_value, CH_VAL);
      cmd0(trim_low_cmd, F_TRIM, err_value, CH_VAL);
      cmd0(trim_high_cmd, F_TRIM, err_value, CH_VAL);
      cmd(raw_set_cmd, 32'h600, 64'h3132410000000000, 32'h0, err_none, 8'h00);
      cmd(raw_set_cmd, 32'h600, 64'h3132580000000000, 32'h0, err_value, CH_VAL);
      cmd0(raw_set_cmd, F_MAN, err_manual, CH_MAN);
      cmd0(other_store_cmd, 32'h0, err_protect, CH_WP);
      cmd(config_read_cmd, 32'h0, 64'h0, 32'h01323112, err_none, 8'h00);
      cmd(config_read_cmd, 32'h0, 64'h0, 32'h01333112, err_checksum, CH_SUM);
   endtask
   task automatic t_addr();
      logic [7:0] bad[6];
      logic [63:0] op;
      bad = '{8'h00, 8'h0d, 8'h24, 8'h23, 8'h80, 8'hff};
      unlock();
      foreach (bad[i]) begin
         cmd(config_store_cmd, F_LEN8, asc({bad[i], 24'h220180}), 32'h0, err_address,
            CH_ADDR);
         chk_word(config_word, CFG_RESET, "setup after bad address");
      end
      cmd(config_store_cmd, F_LEN7, asc(32'h31220180), 32'h0, err_syntax, CH_SYN);
      op = asc(32'h31220180);
      // Host aborts the store with a non-hex character
      op[23:16] = 8'h58;
      cmd(config_store_cmd, F_LEN8, op, 32'h0, err_syntax, CH_SYN);
      chk_word(config_word, CFG_RESET, "setup after cancel");
      chk_bit(write_enable, 1'b1, "latch lost");
   endtask
   task automatic t_store();
      cmd(config_store_cmd, F_LEN8, asc(32'h31220180), 32'h0, err_none, 8'h00);
      chk_word(config_word, 32'h31220180, "stored setup");
      chk_bit(st[25], 1'b1, "parity not pending");
      chk_word({26'h0, link_cfg}, 32'h7, "link changed early");
      chk_bit(write_enable, 1'b0, "latch after store");
      cmd0(config_read_cmd, F_PAR, err_none, 8'h00);
      rd(REG_CONFIG, rv);
      chk_word(rv, 32'h31220180, "setup read");
      wr(REG_CTRL, 32'h2);
      // Parity moves at the completion edge; look one edge later
      @(posedge pclk);
      chk_word({26'h0, link_cfg}, 32'h0f, "parity not applied");
      cmd0(config_read_cmd, F_PAR, err_parity, CH_PAR);
      unlock();
      cmd0(remote_restart_cmd, 32'h0, err_none, 8'h00);
      chk_word({26'h0, link_cfg}, 32'h0a, "baud not applied");
      chk_bit(write_enable, 1'b0, "latch after restart");
      unlock();
      run({4'h0, config_store_cmd}, F_LEN8, asc(32'h32020180), 32'h0);
      chk_word(config_word, 32'h32020180, "new address");
      cur_addr = 8'h32;
      cmd0(config_read_cmd, F_SYN, err_syntax, CH_SYN);
   endtask

   // =====================================================================
   // Main sequence and watchdog
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      n_mismatch = 0;
      comparisons = 0;
      cur_addr = CFG_RESET[31:24];
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_protect();
      t_keep();
      t_errors();
      t_addr();
      t_store();
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      fail("watchdog expired");
      stop_test();
   end
endmodule // tb
